// >>> hdl/tif_map.vh
// Register map, field positions, reset values and codes for the timer flag block.
// Assumes an 8-bit register port with byte addresses as listed here.
//
// Functional notes
// - Overflow request needs enable, global flag, overflow flag
// - Flag bits 7:6 and 4 read zero
// - Capture pin event sets capture flag
// - Capture-top modes set capture flag at top
// - Compare flag sets one timer clock after equality
// - Forced compare strobe never sets match flag
// - Normal and CTC modes: overflow sets overflow flag
// - Vector execution clears its flag
// - Writing one clears flag, zero keeps it
// - Timer four out-mode fields drive no pin
// - Non-PWM out-mode zero normal, others reserved
// - Mode built from control A 1:0, B 4:3
// - Mode 0 normal, 4/C CTC, D reserved
// - Modes 1-3, A, B phase correct PWM
// - Modes 8, 9 phase-and-frequency correct PWM
// - Modes 5-7, E, F fast PWM
// - Timer four waveform stays internal, no pins
// - Noise filter bit stored, no effect
// - Clock select: stop, /1, prescaled, reserved
`ifndef TIF_MAP_VH
`define TIF_MAP_VH

`define TIF_ADDR_T3_FLAGS      8'h38
`define TIF_ADDR_T3_MASK       8'h71
`define TIF_ADDR_T4_CTRL_A     8'hA0
`define TIF_ADDR_T4_CTRL_B     8'hA1

`define TIF_RST_T3_FLAGS       8'h00
`define TIF_RST_T3_MASK        8'h00
`define TIF_RST_T4_CTRL_A      8'h00
`define TIF_RST_T4_CTRL_B      8'h00

`define TIF_FLAG_OVF           0
`define TIF_FLAG_MATCH_A       1
`define TIF_FLAG_MATCH_B       2
`define TIF_FLAG_MATCH_C       3
`define TIF_FLAG_CAPTURE       5
`define TIF_FLAG_WMASK         8'h2F
`define TIF_MASK_OVF_EN        0

`define TIF_CA_OUT_A_MSB       7
`define TIF_CA_OUT_A_LSB       6
`define TIF_CA_OUT_B_MSB       5
`define TIF_CA_OUT_B_LSB       4
`define TIF_CA_OUT_C_MSB       3
`define TIF_CA_OUT_C_LSB       2
`define TIF_CA_WGM_MSB         1
`define TIF_CA_WGM_LSB         0
`define TIF_CB_NOISE           7
`define TIF_CB_EDGE            6
`define TIF_CB_WGM_MSB         4
`define TIF_CB_WGM_LSB         3
`define TIF_CB_CS_MSB          2
`define TIF_CB_CS_LSB          0
`define TIF_CB_WMASK           8'hDF

`define TIF_CS_STOP            3'h0
`define TIF_CS_DIV1            3'h1
`define TIF_CS_DIV8            3'h2
`define TIF_CS_DIV64           3'h3
`define TIF_CS_DIV256          3'h4
`define TIF_CS_DIV1024         3'h5

`define TIF_PRE_MASK8          10'h007
`define TIF_PRE_MASK64         10'h03F
`define TIF_PRE_MASK256        10'h0FF
`define TIF_PRE_MASK1024       10'h3FF

`define TIF_TOP_FIXED          2'h0
`define TIF_TOP_CMP_A          2'h1
`define TIF_TOP_CAPTURE        2'h2

`endif

// >>> hdl/tif_timer_flags_ctrl.v
// Timer three interrupt flags with overflow request, timer four control registers.
// Assumes counter, compare and prescaled-tick sources on mclk; capture pin is asynchronous.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tif_map.vh"

module tif_timer_flags_ctrl (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrStb,
  input  wire       regRdStb,
  output reg  [7:0] regRdData_r,
  input  wire       globalIrqEnable,
  input  wire [3:0] t3WaveformMode,
  input  wire       t3Tick,
  input  wire       t3Overflow,
  input  wire       t3AtTop,
  input  wire       t3AtBottom,
  input  wire [2:0] t3CompareEqual,
  input  wire [2:0] t3ForceMatch,
  input  wire       t3CapturePin,
  input  wire       t3CaptureRising,
  input  wire       t3OvfVectorAck,
  input  wire       t3CapVectorAck,
  input  wire [2:0] t3MatchVectorAck,
  output reg        t3OverflowIrq_r,
  output reg  [4:0] t3FlagState_r,
  output reg  [2:0] t3ForcedMatch_r,
  output reg  [3:0] t4WaveformMode_r,
  output reg  [5:0] t4ModeClass_r,
  output reg  [1:0] t4TopSource_r,
  output reg        t4OutModeReserved_r,
  output reg        t4CountTick_r
);

  localparam [5:0] CL_NORMAL = 6'h01;
  localparam [5:0] CL_CTC    = 6'h02;
  localparam [5:0] CL_PCPWM  = 6'h04;
  localparam [5:0] CL_PFCPWM = 6'h08;
  localparam [5:0] CL_FAST   = 6'h10;
  localparam [5:0] CL_RSVD   = 6'h20;
  localparam [7:0] FLAG_RST  = `TIF_RST_T3_FLAGS;

  // Mode class decode
  function [5:0] modeClass;
    input [3:0] m;
    begin
      case (m)
        4'h0:                modeClass = CL_NORMAL;
        4'h4, 4'hC:          modeClass = CL_CTC;
        4'h1, 4'h2, 4'h3,
        4'hA, 4'hB:          modeClass = CL_PCPWM;
        4'h8, 4'h9:          modeClass = CL_PFCPWM;
        4'h5, 4'h6, 4'h7,
        4'hE, 4'hF:          modeClass = CL_FAST;
        default:             modeClass = CL_RSVD;
      endcase
    end
  endfunction

  // Source of the counter maximum
  function [1:0] topSource;
    input [3:0] m;
    begin
      case (m)
        4'h8, 4'hA, 4'hE:    topSource = `TIF_TOP_CAPTURE;
        4'h4, 4'h9, 4'hB,
        4'hC, 4'hF:          topSource = `TIF_TOP_CMP_A;
        default:             topSource = `TIF_TOP_FIXED;
      endcase
    end
  endfunction

  wire [7:0] t3Flags_r;
  reg  [7:0] t3Mask_r;
  reg  [7:0] t4CtrlA_r;
  reg  [7:0] t4CtrlB_r;
  reg  [2:0] eqPending_r;
  wire       capSync2_r;
  reg        capPrev_r;
  reg  [9:0] preCnt_r;
  reg        tickNxt;
  reg  [7:0] rdNxt;
  reg        ovfEvent;
  reg  [7:0] setBits;
  reg  [7:0] clrBits;

  wire       wrFlags = regWrStb && (regAddr == `TIF_ADDR_T3_FLAGS);
  wire       wrMask  = regWrStb && (regAddr == `TIF_ADDR_T3_MASK);
  wire       wrCtrlA = regWrStb && (regAddr == `TIF_ADDR_T4_CTRL_A);
  wire       wrCtrlB = regWrStb && (regAddr == `TIF_ADDR_T4_CTRL_B);
  wire [5:0] t3Class = modeClass(t3WaveformMode);
  wire [5:0] t4ClassNxt;
  wire [3:0] t4ModeNxt;
  wire [2:0] clkSel = t4CtrlB_r[`TIF_CB_CS_MSB:`TIF_CB_CS_LSB];
  wire       capEdge;

  assign t4ModeNxt  = {t4CtrlB_r[`TIF_CB_WGM_MSB:`TIF_CB_WGM_LSB],
                       t4CtrlA_r[`TIF_CA_WGM_MSB:`TIF_CA_WGM_LSB]};
  assign t4ClassNxt = modeClass(t4ModeNxt);
  assign capEdge    = t3CaptureRising ? (capSync2_r && !capPrev_r)
                                      : (!capSync2_r && capPrev_r);

  // Capture pin synchroniser and edge history
  tif_sync2 u_capSync (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .asyncIn   (t3CapturePin),
    .syncOut_r (capSync2_r)
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      capPrev_r <= 1'b0;
    else
      capPrev_r <= capSync2_r;
  end

  // Overflow event per mode
  always @* begin
    case (t3Class)
      CL_NORMAL, CL_CTC: ovfEvent = t3Overflow;
      CL_FAST:           ovfEvent = t3AtTop;
      CL_PCPWM,
      CL_PFCPWM:         ovfEvent = t3AtBottom;
      default:           ovfEvent = 1'b0;
    endcase
  end

  // Flag set and clear terms; set wins
  always @* begin
    setBits = 8'h00;
    clrBits = 8'h00;
    setBits[`TIF_FLAG_OVF] = ovfEvent;
    setBits[`TIF_FLAG_CAPTURE] = capEdge ||
      (t3AtTop && (topSource(t3WaveformMode) == `TIF_TOP_CAPTURE));
    setBits[`TIF_FLAG_MATCH_C:`TIF_FLAG_MATCH_A] =
      t3Tick ? eqPending_r : 3'h0;
    if (wrFlags)
      clrBits = regWrData & `TIF_FLAG_WMASK;
    clrBits[`TIF_FLAG_OVF] = clrBits[`TIF_FLAG_OVF] | t3OvfVectorAck;
    clrBits[`TIF_FLAG_CAPTURE] = clrBits[`TIF_FLAG_CAPTURE] | t3CapVectorAck;
    clrBits[`TIF_FLAG_MATCH_C:`TIF_FLAG_MATCH_A] =
      clrBits[`TIF_FLAG_MATCH_C:`TIF_FLAG_MATCH_A] | t3MatchVectorAck;
  end

  // Reserved flag positions
  assign t3Flags_r[7:6] = 2'h0;
  assign t3Flags_r[4]   = 1'b0;

  // One cell per flag; set wins over clear
  tif_flag_cell #(
    .RST_VAL (FLAG_RST[`TIF_FLAG_OVF])
  ) u_flagOvf (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .setEvt (setBits[`TIF_FLAG_OVF]),
    .clrEvt (clrBits[`TIF_FLAG_OVF]),
    .flag_r (t3Flags_r[`TIF_FLAG_OVF])
  );

  tif_flag_cell #(
    .RST_VAL (FLAG_RST[`TIF_FLAG_MATCH_A])
  ) u_flagMatchA (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .setEvt (setBits[`TIF_FLAG_MATCH_A]),
    .clrEvt (clrBits[`TIF_FLAG_MATCH_A]),
    .flag_r (t3Flags_r[`TIF_FLAG_MATCH_A])
  );

  tif_flag_cell #(
    .RST_VAL (FLAG_RST[`TIF_FLAG_MATCH_B])
  ) u_flagMatchB (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .setEvt (setBits[`TIF_FLAG_MATCH_B]),
    .clrEvt (clrBits[`TIF_FLAG_MATCH_B]),
    .flag_r (t3Flags_r[`TIF_FLAG_MATCH_B])
  );

  tif_flag_cell #(
    .RST_VAL (FLAG_RST[`TIF_FLAG_MATCH_C])
  ) u_flagMatchC (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .setEvt (setBits[`TIF_FLAG_MATCH_C]),
    .clrEvt (clrBits[`TIF_FLAG_MATCH_C]),
    .flag_r (t3Flags_r[`TIF_FLAG_MATCH_C])
  );

  tif_flag_cell #(
    .RST_VAL (FLAG_RST[`TIF_FLAG_CAPTURE])
  ) u_flagCapture (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .setEvt (setBits[`TIF_FLAG_CAPTURE]),
    .clrEvt (clrBits[`TIF_FLAG_CAPTURE]),
    .flag_r (t3Flags_r[`TIF_FLAG_CAPTURE])
  );

  // Timer three mask and compare pipeline
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t3Mask_r        <= `TIF_RST_T3_MASK;
      eqPending_r     <= 3'h0;
      t3ForcedMatch_r <= 3'h0;
    end else begin
      if (wrMask)
        t3Mask_r <= regWrData & 8'h01;
      if (t3Tick)
        eqPending_r <= t3CompareEqual;
      t3ForcedMatch_r <= t3ForceMatch;
    end
  end

  // Interrupt request and flag view
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t3OverflowIrq_r <= 1'b0;
      t3FlagState_r   <= 5'h00;
    end else begin
      t3OverflowIrq_r <= t3Mask_r[`TIF_MASK_OVF_EN] && globalIrqEnable &&
                         t3Flags_r[`TIF_FLAG_OVF];
      t3FlagState_r   <= {t3Flags_r[`TIF_FLAG_CAPTURE],
                          t3Flags_r[`TIF_FLAG_MATCH_C:`TIF_FLAG_OVF]};
    end
  end

  // Timer four control registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t4CtrlA_r <= `TIF_RST_T4_CTRL_A;
      t4CtrlB_r <= `TIF_RST_T4_CTRL_B;
    end else begin
      if (wrCtrlA)
        t4CtrlA_r <= regWrData;
      if (wrCtrlB)
        t4CtrlB_r <= regWrData & `TIF_CB_WMASK;
    end
  end

  // Timer four mode decode, internal only
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t4WaveformMode_r    <= 4'h0;
      t4ModeClass_r       <= CL_NORMAL;
      t4TopSource_r       <= `TIF_TOP_FIXED;
      t4OutModeReserved_r <= 1'b0;
    end else begin
      t4WaveformMode_r <= t4ModeNxt;
      t4ModeClass_r    <= t4ClassNxt;
      t4TopSource_r    <= topSource(t4ModeNxt);
      t4OutModeReserved_r <= ((t4ClassNxt == CL_NORMAL) || (t4ClassNxt == CL_CTC)) &&
        (t4CtrlA_r[`TIF_CA_OUT_A_MSB:`TIF_CA_OUT_C_LSB] != 6'h00);
    end
  end

  // Prescaler tick select
  always @* begin
    case (clkSel)
      `TIF_CS_STOP:    tickNxt = 1'b0;
      `TIF_CS_DIV1:    tickNxt = 1'b1;
      `TIF_CS_DIV8:    tickNxt = ((preCnt_r & `TIF_PRE_MASK8) == `TIF_PRE_MASK8);
      `TIF_CS_DIV64:   tickNxt = ((preCnt_r & `TIF_PRE_MASK64) == `TIF_PRE_MASK64);
      `TIF_CS_DIV256:  tickNxt = ((preCnt_r & `TIF_PRE_MASK256) == `TIF_PRE_MASK256);
      `TIF_CS_DIV1024: tickNxt = (preCnt_r == `TIF_PRE_MASK1024);
      default:         tickNxt = 1'b0;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_r      <= 10'h000;
      t4CountTick_r <= 1'b0;
    end else begin
      preCnt_r      <= preCnt_r + 10'h001;
      t4CountTick_r <= tickNxt;
    end
  end

  // Read mux
  always @* begin
    case (regAddr)
      `TIF_ADDR_T3_FLAGS:  rdNxt = t3Flags_r & `TIF_FLAG_WMASK;
      `TIF_ADDR_T3_MASK:   rdNxt = t3Mask_r;
      `TIF_ADDR_T4_CTRL_A: rdNxt = t4CtrlA_r;
      `TIF_ADDR_T4_CTRL_B: rdNxt = t4CtrlB_r;
      default:             rdNxt = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      regRdData_r <= 8'h00;
    else if (regRdStb)
      regRdData_r <= rdNxt;
    else
      regRdData_r <= 8'h00;
  end

endmodule // tif_timer_flags_ctrl

// One interrupt flag bit, set wins over clear
module tif_flag_cell #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input  wire mclk,
  input  wire rst_n,
  input  wire setEvt,
  input  wire clrEvt,
  output reg  flag_r
);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      flag_r <= RST_VAL;
    else if (setEvt)
      flag_r <= 1'b1;
    else if (clrEvt)
      flag_r <= 1'b0;
  end

endmodule // tif_flag_cell

// Two-stage synchroniser for an asynchronous pin
module tif_sync2 (
  input  wire mclk,
  input  wire rst_n,
  input  wire asyncIn,
  output reg  syncOut_r
);

  reg metaStage_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      metaStage_r <= 1'b0;
      syncOut_r   <= 1'b0;
    end else begin
      metaStage_r <= asyncIn;
      syncOut_r   <= metaStage_r;
    end
  end

endmodule // tif_sync2
`default_nettype wire

// >>> sim/tif_timer_flags_ctrl_monitor.sv
// Property checker for the timer flag and control block.
// Assumes one mclk domain with asynchronous active-low rst_n; bound below.
`timescale 1ns/1ps
`default_nettype none
`include "tif_map.vh"
module tif_timer_flags_ctrl_monitor (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrStb,
  input wire logic       regRdStb,
  input wire logic [7:0] regRdData_r,
  input wire logic       globalIrqEnable,
  input wire logic [3:0] t3WaveformMode,
  input wire logic       t3Tick,
  input wire logic       t3Overflow,
  input wire logic       t3AtTop,
  input wire logic       t3AtBottom,
  input wire logic [2:0] t3CompareEqual,
  input wire logic       t3OvfVectorAck,
  input wire logic       t3OverflowIrq_r,
  input wire logic [4:0] t3FlagState_r,
  input wire logic [3:0] t4WaveformMode_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire logic noEvt;
  wire logic flagRd;
  assign noEvt  = !t3Overflow && !t3AtTop && !t3AtBottom;
  assign flagRd = regAddr == `TIF_ADDR_T3_FLAGS;

  chk_rd_resv_zero: assert property (regRdStb && flagRd |=> !regRdData_r[4] &&
    regRdData_r[7:6] == 2'h0) else $error("Reserved flag bit read as one");
  chk_rd_idle: assert property (!$past(regRdStb) |-> regRdData_r == 8'h00)
    else $error("Read data not zero outside answer cycle");
  chk_irq_cause: assert property (t3OverflowIrq_r |-> t3FlagState_r[0] &&
    $past(globalIrqEnable)) else $error("Overflow request without its causes");
  chk_ovf_sets: assert property (t3Overflow && t3WaveformMode[1:0] == 2'h0 &&
    !t3WaveformMode[3] |-> ##2 t3FlagState_r[0]) else $error("Overflow flag not set");
  chk_match_sets: assert property (t3Tick && t3CompareEqual[0] ##1 t3Tick |->
    ##2 t3FlagState_r[1]) else $error("Match A flag not set one tick after equality");
  chk_w1c_clears: assert property (regWrStb && flagRd && regWrData[0] && noEvt |->
    ##2 !t3FlagState_r[0]) else $error("Write one did not clear overflow flag");
  chk_ack_clears: assert property (t3OvfVectorAck && noEvt |-> ##2 !t3FlagState_r[0])
    else $error("Vector ack did not clear overflow flag");
  chk_mode_low: assert property (regWrStb && regAddr == `TIF_ADDR_T4_CTRL_A ##1
    !regWrStb |-> ##1 t4WaveformMode_r[1:0] == $past(regWrData[1:0], 2))
    else $error("Mode low bits not taken from control A");

  cover property (t3OverflowIrq_r);
  cover property ($rose(t3FlagState_r[4]));
  cover property (t4WaveformMode_r == 4'hF);
endmodule // tif_timer_flags_ctrl_monitor

bind tif_timer_flags_ctrl tif_timer_flags_ctrl_monitor u_mon (.*);
`default_nettype wire

// >>> sim/tif_timer_flags_ctrl_bench.sv
// Self-checking bench for the timer flag and control block.
// Assumes the block alone on mclk; the bench plays CPU, counter and capture pin.
`timescale 1ns/1ps
`default_nettype none
`include "tif_map.vh"
module tif_timer_flags_ctrl_bench;
  localparam logic [7:0] FL = `TIF_ADDR_T3_FLAGS;
  localparam logic [7:0] CB = `TIF_ADDR_T4_CTRL_B;
  logic       mclk, rst_n, regWrStb, regRdStb, globalIrqEnable, t3Tick, t3Overflow;
  logic       t3AtTop, t3AtBottom, t3CapturePin, t3CaptureRising, t3OvfVectorAck;
  logic       t3CapVectorAck, t3OverflowIrq_r, t4OutModeReserved_r, t4CountTick_r;
  logic [7:0] regAddr, regWrData, regRdData_r;
  logic [3:0] t3WaveformMode, t4WaveformMode_r;
  logic [2:0] t3CompareEqual, t3ForceMatch, t3MatchVectorAck, t3ForcedMatch_r;
  logic [4:0] t3FlagState_r;
  logic [5:0] t4ModeClass_r;
  logic [1:0] t4TopSource_r;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         cyc = 0;

  tif_timer_flags_ctrl u_dut (.*);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] ex);
    n_tests++;
    if (got !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge mclk);
    regWrStb <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] ex);
    @(posedge mclk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1 chk(nm, {8'h00, regRdData_r}, {8'h00, ex});
  endtask
  // Pulses {wrap, top, bottom, overflow ack, capture ack} for one cycle
  task automatic ev(input logic [4:0] v);
    @(posedge mclk);
    {t3Overflow, t3AtTop, t3AtBottom, t3OvfVectorAck, t3CapVectorAck} <= v;
    @(posedge mclk);
    {t3Overflow, t3AtTop, t3AtBottom, t3OvfVectorAck, t3CapVectorAck} <= 5'h00;
  endtask
  // Expected {top source, mode class} per waveform mode
  function automatic logic [7:0] cls(input logic [3:0] m);
    case (m)
      4'h0: cls = 8'h01;
      4'h4, 4'hC: cls = 8'h42;
      4'h1, 4'h2, 4'h3: cls = 8'h04;
      4'hA: cls = 8'h84;
      4'hB: cls = 8'h44;
      4'h8: cls = 8'h88;
      4'h9: cls = 8'h48;
      4'h5, 4'h6, 4'h7: cls = 8'h10;
      4'hE: cls = 8'h90;
      4'hF: cls = 8'h50;
      default: cls = 8'h20;
    endcase
  endfunction

  task automatic t_regs();
    rdc("flags", FL, 8'h00);
    rdc("ctrl a", `TIF_ADDR_T4_CTRL_A, 8'h00);
    rdc("ctrl b", CB, 8'h00);
    rdc("unmapped", 8'h55, 8'h00);
    wr(CB, 8'hFF);
    rdc("ctrl b stored", CB, 8'hDF);
    wr(CB, 8'h00);
    wr(FL, 8'hFF);
    rdc("flag reserved", FL, 8'h00);
  endtask
  task automatic t_ovf();
    logic [3:0] md[5] = '{4'h0, 4'h4, 4'h5, 4'h1, 4'hD};
    logic [4:0] e[5] = '{5'h10, 5'h10, 5'h08, 5'h04, 5'h10};
    for (int i = 0; i < 5; i++) begin
      t3WaveformMode <= md[i];
      ev(e[i]);
      rdc("ovf set", FL, (i == 4) ? 8'h00 : 8'h01);
      wr(FL, 8'h00);
      rdc("ovf kept", FL, (i == 4) ? 8'h00 : 8'h01);
      if (i[0]) ev(5'h02);
      else wr(FL, 8'h01);
      rdc("ovf clear", FL, 8'h00);
    end
  endtask
  task automatic t_irq();
    t3WaveformMode <= 4'h0;
    for (int g = 0; g < 3; g++) begin
      wr(`TIF_ADDR_T3_MASK, (g > 1) ? 8'h00 : 8'h01);
      globalIrqEnable <= (g > 0);
      ev(5'h10);
      @(posedge mclk);
      #1 chk("irq", {15'h0000, t3OverflowIrq_r}, {15'h0000, g == 1});
      wr(FL, 8'h01);
      repeat (2) @(posedge mclk);
      #1 chk("irq drop", {15'h0000, t3OverflowIrq_r}, 16'h0000);
    end
  endtask
  task automatic t_cap();
    logic [3:0] md[4] = '{4'h8, 4'hA, 4'hE, 4'hF};
    logic [7:0] ex[4] = '{8'h20, 8'h20, 8'h21, 8'h01};
    for (int r = 1; r >= 0; r--) begin
      t3CaptureRising <= r[0];
      @(posedge mclk);
      t3CapturePin <= r[0];
      repeat (5) @(posedge mclk);
      rdc("pin capture", FL, 8'h20);
      wr(FL, 8'h20);
    end
    for (int i = 0; i < 4; i++) begin
      t3WaveformMode <= md[i];
      ev(5'h08);
      rdc("top capture", FL, ex[i]);
      wr(FL, 8'h21);
    end
  endtask
  task automatic t_cmp();
    @(posedge mclk);
    t3Tick <= 1'b1;
    t3ForceMatch <= 3'h7;
    @(posedge mclk);
    t3ForceMatch <= 3'h0;
    #1 chk("forced strobe", {13'h0000, t3ForcedMatch_r}, 16'h0007);
    repeat (4) @(posedge mclk);
    rdc("forced", FL, 8'h00);
    for (int c = 0; c < 3; c++) begin
      @(posedge mclk);
      t3CompareEqual <= 3'h1 << c;
      @(posedge mclk);
      t3CompareEqual <= 3'h0;
      t3Tick <= (c == 0);
      repeat (3) @(posedge mclk);
      rdc("match early", FL, (c == 0) ? 8'h02 : 8'h00);
      t3Tick <= 1'b1;
      repeat (2) @(posedge mclk);
      rdc("match set", FL, 8'h02 << c);
      @(posedge mclk);
      t3MatchVectorAck <= 3'h1 << c;
      @(posedge mclk);
      t3MatchVectorAck <= 3'h0;
      rdc("match ack", FL, 8'h00);
    end
  endtask
  task automatic t_modes();
    for (int m = 0; m < 16; m++) begin
      wr(`TIF_ADDR_T4_CTRL_A, (m[0] ? 8'h00 : 8'h04) | {6'h00, m[1:0]});
      wr(CB, {3'h0, m[3:2], 3'h0});
      repeat (2) @(posedge mclk);
      #1 chk("mode", {12'h000, t4WaveformMode_r}, m[15:0]);
      chk("class", {8'h00, t4TopSource_r, t4ModeClass_r}, {8'h00, cls(m[3:0])});
      chk("out reserved", {15'h0000, t4OutModeReserved_r}, {15'h0000, m % 4 == 0 && m != 8});
    end
  endtask
  task automatic t_clk();
    logic [15:0] ex[8] = '{16'h0000, 16'h0400, 16'h0080, 16'h0010, 16'h0004, 16'h0001,
                           16'h0000, 16'h0000};
    logic [15:0] n;
    for (int s = 0; s < 8; s++) begin
      wr(CB, {5'h00, s[2:0]});
      repeat (3) @(posedge mclk);
      n = 16'h0000;
      repeat (1024) begin
        @(posedge mclk);
        #1 n = n + {15'h0000, t4CountTick_r};
      end
      chk("ticks", n, ex[s]);
    end
  endtask

  initial begin
    {regAddr, regWrData, regWrStb, regRdStb, globalIrqEnable, t3WaveformMode} = '0;
    {t3Tick, t3Overflow, t3AtTop, t3AtBottom, t3CompareEqual, t3ForceMatch} = '0;
    {t3CapturePin, t3CaptureRising, t3OvfVectorAck, t3CapVectorAck, t3MatchVectorAck} = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_ovf();
    t_irq();
    t_cap();
    t_cmp();
    t_modes();
    t_clk();
    report_and_stop();
  end
endmodule // tif_timer_flags_ctrl_bench
`default_nettype wire
